// file: hw/scr_cfg.svh
`ifndef SCR_CFG_SVH
`define SCR_CFG_SVH
// register pointers
`define SCR_PTR_MEAS_BASE   8'h08
`define SCR_PTR_GAIN_BASE   8'h11
`define SCR_PTR_GAIN_LAST   8'h14
`define SCR_PTR_OFFSET_CAL  8'h0d
// measurement configuration fields
`define SCR_POS_MSB         15
`define SCR_POS_LSB         13
`define SCR_NEG_MSB         12
`define SCR_NEG_LSB         10
`define SCR_DAC_MSB         9
`define SCR_DAC_LSB         5
`define SCR_NEG_SINGLE_A    3'h4
`define SCR_NEG_SINGLE_B    3'h7
`define SCR_NEG_DIFF_LIMIT  3'h4
// reset values
`define SCR_OFFSET_DEFAULT  16'h0000
`define SCR_MEAS_DEFAULT    16'h1c00
`endif

// file: hw/scr_pkg.sv
package scr_pkg;
  typedef enum logic [1:0] {
    SCR_MODE_DIFF,
    SCR_MODE_SE_SHORT,
    SCR_MODE_SE_DAC
  } scr_mode_e;

  // shield output routing: which sense input each shield follows
  typedef struct packed {
    logic       first_en;
    logic [1:0] first_sel;
    logic       second_en;
    logic [1:0] second_sel;
    logic       shorted;
  } scr_shield_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  ptr;
    logic [15:0] wdata;
  } scr_reg_req_s;
endpackage : scr_pkg

// file: hw/scr_shield_routing.sv
`timescale 1ns/1ps
`default_nettype none
`include "scr_cfg.svh"
// Function
// R1 - differential: first shield follows the lower input, second the higher.
// R2 - single-ended without offset-cancel dac: the two shields are shorted.
// R3 - single-ended with dac: first shield drives, second floats.
// R4 - each active shield follows the waveform of its assigned sense input.
// R5 - result is input capacitance minus the dac capacitance of that input.
// R6 - the dac code is 5 bits with a monotonic transfer.
// R7 - offset calibration register returns to its default on every reset.
// R8 - host keeps and rewrites its offset calibration after power-up.
// R9 - host removes big offsets with the dac first, then trims with offset cal.
// R10 - four writable gain trim registers at 0x11..0x14 override the gain.
// R11 - reset restores every gain trim register to its factory coefficient.
// R12 - negative select of 100 or 111 means single-ended.
// R13 - negative select below 100 means differential; dac then has no effect.
// R14 - the dac code sits in bits 9:5 of the measurement configuration.
// R15 - routing and dac are settled before excitation starts.
// R16 - gain trim registers are 16 bits, sent most significant byte first.
module scr_shield_routing
  import scr_pkg::*;
(
  input  wire logic         ref_clk,        // core clock
  input  wire logic         sys_rst,        // async reset, high
  input  wire scr_reg_req_s reg_req,        // decoded register access
  input  wire logic [1:0]   meas_sel,       // active measurement
  input  wire logic         meas_start,     // pulse: begin a measurement
  input  wire logic [3:0][15:0] factory_gain, // otp gain words, input 0..3
  input  wire logic [15:0]  raw_cap,        // raw capacitance code
  input  wire logic [15:0]  dac_cap,        // dac capacitance for code
  output var  logic [15:0]  reg_rdata,      // read data
  output var  logic         reg_nack,       // unmapped pointer
  output var  logic [15:0]  gain_active,    // gain for current input
  output var  scr_shield_s  shield,         // shield routing
  output var  logic [4:0]   dac_code,       // active dac code
  output var  logic         excite,         // excitation enable
  output var  logic [15:0]  result          // capacitance minus dac
);
  logic [3:0][15:0] meas_cfg, next_meas_cfg;
  logic [3:0][15:0] gain_trim, next_gain_trim;
  logic [15:0] offset_cal, next_offset_cal;
  logic        gain_loaded, next_gain_loaded;
  logic [15:0] next_rdata;
  logic        next_nack;
  logic [15:0] next_gain_active, next_result;
  scr_shield_s next_shield;
  logic [4:0]  next_dac;
  logic        next_excite, settle, next_settle;
  logic [15:0] cfg;
  logic [2:0]  pos, neg;
  scr_mode_e   mode;

  assign cfg = meas_cfg[meas_sel];
  assign pos = cfg[`SCR_POS_MSB:`SCR_POS_LSB];
  assign neg = cfg[`SCR_NEG_MSB:`SCR_NEG_LSB];

  always_comb begin
    if (neg < `SCR_NEG_DIFF_LIMIT) begin
      mode = SCR_MODE_DIFF; // R13
    end else if (neg == `SCR_NEG_SINGLE_A || neg == `SCR_NEG_SINGLE_B) begin
      // zero dac code counts as dac disabled
      mode = (cfg[`SCR_DAC_MSB:`SCR_DAC_LSB] == 5'h00) ?
             SCR_MODE_SE_SHORT : SCR_MODE_SE_DAC; // R12
    end else begin
      mode = SCR_MODE_SE_SHORT;
    end
  end

  always_comb begin
    next_meas_cfg    = meas_cfg;
    next_gain_trim   = gain_trim;
    next_offset_cal  = offset_cal;
    next_gain_loaded = 1'b1;
    next_rdata       = reg_rdata;
    next_nack        = 1'b0;
    if (!gain_loaded) begin
      // otp words are captured after reset release, never under the reset
      for (int i = 0; i < 4; i++) begin
        next_gain_trim[i] = factory_gain[i]; // R11
      end
    end
    if (reg_req.wr || reg_req.rd) begin
      if (reg_req.ptr >= `SCR_PTR_MEAS_BASE &&
          reg_req.ptr < `SCR_PTR_MEAS_BASE + 8'h04) begin
        if (reg_req.wr) begin
          next_meas_cfg[reg_req.ptr[1:0]] = reg_req.wdata;
        end
        next_rdata = meas_cfg[reg_req.ptr[1:0]];
      end else if (reg_req.ptr >= `SCR_PTR_GAIN_BASE &&
                   reg_req.ptr <= `SCR_PTR_GAIN_LAST) begin
        // whole 16-bit word, msb byte first on the wire // R16
        if (reg_req.wr) begin
          next_gain_trim[2'(reg_req.ptr - `SCR_PTR_GAIN_BASE)] =
            reg_req.wdata; // R10
        end
        next_rdata = gain_trim[2'(reg_req.ptr - `SCR_PTR_GAIN_BASE)];
      end else if (reg_req.ptr == `SCR_PTR_OFFSET_CAL) begin
        if (reg_req.wr) begin
          next_offset_cal = reg_req.wdata;
        end
        next_rdata = offset_cal;
      end else begin
        next_nack  = 1'b1;
        next_rdata = 16'h0000;
      end
    end
  end

  always_comb begin
    next_shield      = '0;
    next_dac         = 5'h00;
    next_excite      = 1'b0;
    next_settle      = 1'b0;
    next_gain_active = gain_trim[pos[1:0]];
    next_result      = result;
    case (mode)
      SCR_MODE_DIFF: begin
        next_shield.first_en   = 1'b1; // R1
        next_shield.second_en  = 1'b1;
        next_shield.first_sel  = (pos < neg) ? pos[1:0] : neg[1:0]; // R1
        next_shield.second_sel = (pos < neg) ? neg[1:0] : pos[1:0]; // R4
      end
      SCR_MODE_SE_SHORT: begin
        next_shield.first_en  = 1'b1;
        next_shield.first_sel = pos[1:0]; // R4
        next_shield.shorted   = 1'b1; // R2
      end
      SCR_MODE_SE_DAC: begin
        next_shield.first_en  = 1'b1; // R3
        next_shield.first_sel = pos[1:0];
        next_dac = cfg[`SCR_DAC_MSB:`SCR_DAC_LSB]; // R14
      end
      default: begin
        next_shield = '0;
      end
    endcase
    // one cycle to settle routing before excitation // R15
    if (meas_start) begin
      next_settle = 1'b1;
    end else if (settle || excite) begin
      next_excite = 1'b1;
    end
    if (meas_start) begin
      next_excite = 1'b0;
    end
    if (excite) begin
      // dac capacitance from a monotonic lookup outside // R6
      next_result = 16'(raw_cap - dac_cap + offset_cal); // R5
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meas_cfg    <= {4{`SCR_MEAS_DEFAULT}};
      gain_trim   <= '0;
      offset_cal  <= `SCR_OFFSET_DEFAULT; // R7
      gain_loaded <= 1'b0;
      reg_rdata   <= 16'h0000;
      reg_nack    <= 1'b0;
      gain_active <= 16'h0000;
      shield      <= '0;
      dac_code    <= 5'h00;
      excite      <= 1'b0;
      settle      <= 1'b0;
      result      <= 16'h0000;
    end else begin
      meas_cfg    <= next_meas_cfg;
      gain_trim   <= next_gain_trim;
      offset_cal  <= next_offset_cal;
      gain_loaded <= next_gain_loaded;
      reg_rdata   <= next_rdata;
      reg_nack    <= next_nack;
      gain_active <= next_gain_active;
      shield      <= next_shield;
      dac_code    <= next_dac;
      excite      <= next_excite;
      settle      <= next_settle;
      result      <= next_result;
    end
  end

  // sampled reset keeps out the release edge: the flops were still held
  // there, so they cannot show the next values one edge later
  a_diff_order: assert property (@(posedge ref_clk) // R1
    disable iff (sys_rst) !sys_rst && (mode == SCR_MODE_DIFF) |=>
      shield.first_en && shield.second_en &&
      (shield.first_sel <= shield.second_sel))
    else $error("diff shield order wrong");
  a_se_short: assert property (@(posedge ref_clk) // R2
    disable iff (sys_rst) !sys_rst && (mode == SCR_MODE_SE_SHORT) |=>
      shield.shorted && !shield.second_en)
    else $error("single-ended shields not shorted");
  a_se_dac_float: assert property (@(posedge ref_clk) // R3
    disable iff (sys_rst) !sys_rst && (mode == SCR_MODE_SE_DAC) |=>
      !shield.second_en && !shield.shorted && shield.first_en)
    else $error("second shield not floating");
  a_shield_follow: assert property (@(posedge ref_clk) // R4
    disable iff (sys_rst) !sys_rst && (mode != SCR_MODE_DIFF) |=>
      shield.first_sel == $past(pos[1:0]))
    else $error("shield not on selected input");
  a_result_diff: assert property (@(posedge ref_clk) // R5
    disable iff (sys_rst) excite |=>
      result == 16'($past(raw_cap) - $past(dac_cap) + $past(offset_cal)))
    else $error("result not input minus dac");
  a_diff_no_dac: assert property (@(posedge ref_clk) // R13
    disable iff (sys_rst) !sys_rst && (mode == SCR_MODE_DIFF) |=>
      dac_code == 5'h00)
    else $error("dac active in differential");
  a_dac_field: assert property (@(posedge ref_clk) // R14
    disable iff (sys_rst) !sys_rst && (mode == SCR_MODE_SE_DAC) |=>
      dac_code == $past(cfg[`SCR_DAC_MSB:`SCR_DAC_LSB]))
    else $error("dac code not from bits 9:5");
  a_gain_write: assert property (@(posedge ref_clk) // R10
    disable iff (sys_rst)
      gain_loaded && reg_req.wr && reg_req.ptr == `SCR_PTR_GAIN_BASE |=>
      gain_trim[0] == $past(reg_req.wdata))
    else $error("gain trim write lost");
  a_gain_restore: assert property (@(posedge ref_clk) // R11
    disable iff (sys_rst) !sys_rst && !gain_loaded |=>
      gain_trim[3] == $past(factory_gain[3]))
    else $error("factory gain not restored");
  a_settle_first: assert property (@(posedge ref_clk) // R15
    disable iff (sys_rst) meas_start |=> !excite ##1 excite)
    else $error("excitation before routing settled");
endmodule : scr_shield_routing
`default_nettype wire

// file: dv/scr_afe_model.sv
`timescale 1ns/1ps
`default_nettype none
module scr_afe_model #(
  parameter logic [15:0] RAW  = 16'h4000,
  parameter logic [15:0] STEP = 16'h0100
) (
  input  wire logic        excite,  // conversion window
  input  wire logic [4:0]  dac_code, // offset-cancel code
  output var  logic [15:0] raw_cap, // sensed capacitance
  output var  logic [15:0] dac_cap  // offset-cancel capacitance
);
  // outside a conversion the front end shows garbage, not a held value
  always_comb begin
    raw_cap = excite ? RAW : ~RAW;
    dac_cap = excite ? STEP * {11'h000, dac_code} : 16'hffff;
  end
endmodule : scr_afe_model
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import scr_pkg::*;
  logic ref_clk = 0, sys_rst = 1, meas_start = 0, excite, reg_nack;
  logic [1:0] meas_sel = 0;
  logic [3:0][15:0] factory_gain;
  logic [15:0] raw_cap, dac_cap, reg_rdata, gain_active, result;
  logic [4:0] dac_code;
  scr_reg_req_s reg_req = '0;
  scr_shield_s shield;
  int fails = 0, num_checks = 0, cyc = 0;
  logic [15:0] trim = 16'h0000; // host copy of the offset calibration
  always #20 ref_clk = ~ref_clk;
  scr_shield_routing dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reg_req(reg_req), .meas_sel(meas_sel), .meas_start(meas_start),
    .factory_gain(factory_gain), .raw_cap(raw_cap), .dac_cap(dac_cap),
    .reg_rdata(reg_rdata), .reg_nack(reg_nack), .gain_active(gain_active),
    .shield(shield), .dac_code(dac_code), .excite(excite), .result(result));
  scr_afe_model afe_u (.excite(excite), .dac_code(dac_code),
    .raw_cap(raw_cap), .dac_cap(dac_cap));
  task automatic chk(input logic [15:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic acc(input logic w, input logic [7:0] p, input logic [15:0] d);
    @(posedge ref_clk);
    reg_req <= '{wr: w, rd: !w, ptr: p, wdata: d};
    @(posedge ref_clk);
    reg_req <= '0;
    #1;
  endtask : acc
  task automatic rd(input logic [7:0] p, input logic [15:0] e);
    acc(0, p, 16'h0000);
    chk(reg_rdata, e, "read");
  endtask : rd
  // configure measurement 0, run it, then check routing and result
  task automatic meas(input logic [15:0] cfg, input logic [4:0] code,
                      input logic [6:0] e, m);
    int n;
    acc(1, 8'h08, cfg);
    @(posedge ref_clk);
    meas_start <= 1;
    @(posedge ref_clk);
    meas_start <= 0;
    #1 chk({15'h0000, excite}, 16'h0000, "settle");
    for (n = 0; n < 20 && excite !== 1'b1; n++) @(posedge ref_clk) #1;
    @(posedge ref_clk) #1;
    chk({9'h000, shield & m}, {9'h000, e & m}, "shield");
    chk({11'h000, dac_code}, {11'h000, code}, "dac");
    chk(result, 16'h4000 - 16'h0100 * code + trim, "result");
    chk(gain_active, 16'hc300 + {14'h0000, cfg[14:13]}, "gain");
  endtask : meas
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    for (int i = 0; i < 4; i++) factory_gain[i] = 16'h5a00 + 16'(i);
    repeat (12) @(posedge ref_clk);
    sys_rst <= 0;
    repeat (2) @(posedge ref_clk);
    rd(8'h0d, 16'h0000);
    for (int i = 0; i < 4; i++) rd(8'h11 + 8'(i), 16'h5a00 + 16'(i));
    for (int i = 0; i < 4; i++) acc(1, 8'h11 + 8'(i), 16'hc300 + 16'(i));
    for (int i = 0; i < 4; i++)
      rd(8'h11 + 8'(i), 16'hc300 + 16'(i));
    acc(1, 8'h0d, 16'h0000);
    acc(0, 8'h20, 16'h0000);
    chk({15'h0000, reg_nack}, 16'h0001, "nack");
    meas(16'h0400, 5'h00, 7'h4a, 7'h7f);
    meas(16'h4060, 5'h00, 7'h4c, 7'h7f);
    meas(16'h3c00, 5'h00, 7'h51, 7'h79);
    meas(16'h3400, 5'h00, 7'h51, 7'h79);
    acc(1, 8'h0d, 16'h0020);
    trim = 16'h0020;
    meas(16'h70a0, 5'h05, 7'h70, 7'h79);
    meas(16'h1c40, 5'h02, 7'h40, 7'h79);
    meas(16'h53e0, 5'h1f, 7'h60, 7'h79);
    @(posedge ref_clk);
    sys_rst <= 1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 0;
    repeat (2) @(posedge ref_clk);
    rd(8'h14, 16'h5a03);
    rd(8'h0d, 16'h0000);
    acc(1, 8'h0d, trim);
    rd(8'h0d, trim);
    final_report();
  end
endmodule : tb
`default_nettype wire
